// >>> rtl/sisl_top.sv
// interrupt status, mask and trigger-mode registers of the rate-converting transceiver
module sisl_top
  import sisl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control port
  input wire logic [sisl_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [sisl_pkg::REG_W-1:0] reg_wdata_i,
  output logic [sisl_pkg::REG_W-1:0] reg_rdata_o,
  output logic interrupt_o,
  // configuration
  input wire logic src_in_use_i,
  input wire logic transmit_block_start_is_input_i,
  input wire logic output_port_slave_i,
  input wire logic user_block_mode_i,
  input wire logic [1:0] clk_ratio_sel_i,
  // raw source conditions
  input wire logic tx_sample_slip_i,
  input wire logic transmit_block_start_i,
  input wire logic output_port_sample_slip_i,
  input wire logic output_master_clock_i,
  input wire logic output_frame_sync_i,
  input wire logic [sisl_pkg::PERIOD_W-1:0] in_frame_period_i,
  input wire logic [sisl_pkg::PERIOD_W-1:0] out_frame_period_i,
  input wire logic sample_valid_i,
  input wire logic signed [sisl_pkg::RAW_W-1:0] left_raw_i,
  input wire logic signed [sisl_pkg::RAW_W-1:0] right_raw_i,
  input wire logic cbuf_d_to_e_event_i,
  input wire logic cbuf_e_to_f_event_i,
  input wire logic receiver_fault_event_i,
  input wire logic varispeed_overflow_i,
  input wire logic converter_tracking_event_i,
  input wire logic ubuf_d_to_e_event_i,
  input wire logic ubuf_e_to_f_event_i,
  input wire logic q_subcode_ready_i,
  input wire logic user_fifo_overwrite_i,
  // clipped converter output
  output logic signed [sisl_pkg::SAMPLE_W-1:0] left_sample_o,
  output logic signed [sisl_pkg::SAMPLE_W-1:0] right_sample_o
);
  import sisl_pkg::*;

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  logic [REG_W-1:0] mask_one_reg;
  logic [REG_W-1:0] mode_one_high_reg;
  logic [REG_W-1:0] mode_one_low_reg;
  logic [REG_W-1:0] mask_two_reg;
  logic [REG_W-1:0] mode_two_high_reg;
  logic [REG_W-1:0] mode_two_low_reg;
  logic [REG_W-1:0] rdata_reg;
  logic interrupt_reg;
  logic signed [SAMPLE_W-1:0] left_reg;
  logic signed [SAMPLE_W-1:0] right_reg;
  logic block_start_prev_reg;

  wire sel_status_one = (reg_addr_i == ADDR_STATUS_ONE);
  wire sel_status_two = (reg_addr_i == ADDR_STATUS_TWO);
  wire sel_mask_one = (reg_addr_i == ADDR_MASK_ONE);
  wire sel_mode_one_high = (reg_addr_i == ADDR_MODE_ONE_HIGH);
  wire sel_mode_one_low = (reg_addr_i == ADDR_MODE_ONE_LOW);
  wire sel_mask_two = (reg_addr_i == ADDR_MASK_TWO);
  wire sel_mode_two_high = (reg_addr_i == ADDR_MODE_TWO_HIGH);
  wire sel_mode_two_low = (reg_addr_i == ADDR_MODE_TWO_LOW);

  wire clear_one = reg_rd_i & sel_status_one;
  wire clear_two = reg_rd_i & sel_status_two;

  // status offsets have no write path, so a stray write there is simply dropped
  wire wr_mask_one = reg_wr_i & sel_mask_one;
  wire wr_mode_one_high = reg_wr_i & sel_mode_one_high;
  wire wr_mode_one_low = reg_wr_i & sel_mode_one_low;
  wire wr_mask_two = reg_wr_i & sel_mask_two;
  wire wr_mode_two_high = reg_wr_i & sel_mode_two_high;
  wire wr_mode_two_low = reg_wr_i & sel_mode_two_low;

  // -----------------------------------------------------------------
  // source conditions
  // -----------------------------------------------------------------
  wire block_start_new = transmit_block_start_i & ~block_start_prev_reg;
  wire tx_slip = ~src_in_use_i & (tx_sample_slip_i |
                 (transmit_block_start_is_input_i & block_start_new));

  logic ratio_mismatch;
  sisl_ratio_check u_ratio_check (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(src_in_use_i & output_port_slave_i),
    .output_master_clock_i(output_master_clock_i),
    .output_frame_sync_i(output_frame_sync_i),
    .clk_ratio_sel_i(clk_ratio_sel_i),
    .mismatch_o(ratio_mismatch)
  );

  wire out_slip = (output_port_slave_i & output_port_sample_slip_i) |
                  ratio_mismatch;

  // periods are inverse to rates, so the same test covers both directions
  wire [PERIOD_W+1:0] in_times_limit = (PERIOD_W+2)'(in_frame_period_i) * (PERIOD_W+2)'(RATIO_LIMIT);
  wire [PERIOD_W+1:0] out_times_limit = (PERIOD_W+2)'(out_frame_period_i) * (PERIOD_W+2)'(RATIO_LIMIT);
  wire ratio_exceeded = ((PERIOD_W+2)'(out_frame_period_i) > in_times_limit) |
                        ((PERIOD_W+2)'(in_frame_period_i) > out_times_limit);

  wire left_hi = left_raw_i > FULL_POS;
  wire left_lo = left_raw_i < FULL_NEG;
  wire right_hi = right_raw_i > FULL_POS;
  wire right_lo = right_raw_i < FULL_NEG;
  wire left_over = sample_valid_i & (left_hi | left_lo);
  wire right_over = sample_valid_i & (right_hi | right_lo);

  wire [SAMPLE_W-1:0] left_clip = left_hi ? FULL_POS[SAMPLE_W-1:0] :
                                  left_lo ? FULL_NEG[SAMPLE_W-1:0] :
                                  left_raw_i[SAMPLE_W-1:0];
  wire [SAMPLE_W-1:0] right_clip = right_hi ? FULL_POS[SAMPLE_W-1:0] :
                                   right_lo ? FULL_NEG[SAMPLE_W-1:0] :
                                   right_raw_i[SAMPLE_W-1:0];

  wire [REG_W-1:0] cond_one;
  assign cond_one[BIT_TX_SLIP] = tx_slip;
  assign cond_one[BIT_OUT_SLIP] = out_slip;
  assign cond_one[BIT_RATIO] = ratio_exceeded;
  assign cond_one[BIT_OVR_L] = left_over;
  assign cond_one[BIT_OVR_R] = right_over;
  assign cond_one[BIT_CBUF_DE] = cbuf_d_to_e_event_i;
  assign cond_one[BIT_CBUF_EF] = cbuf_e_to_f_event_i;
  assign cond_one[BIT_RX_FAULT] = receiver_fault_event_i;

  wire [REG_W-1:0] cond_two;
  assign cond_two[7:6] = 2'h0;
  assign cond_two[BIT_VARISPEED] = varispeed_overflow_i;
  assign cond_two[BIT_TRACKING] = converter_tracking_event_i;
  assign cond_two[BIT_UBUF_DE] = user_block_mode_i & ubuf_d_to_e_event_i;
  assign cond_two[BIT_UBUF_EF] = user_block_mode_i & ubuf_e_to_f_event_i;
  // the host has a bounded window to drain the block after this fires
  assign cond_two[BIT_Q_READY] = q_subcode_ready_i;
  assign cond_two[BIT_UFIFO_OVW] = user_fifo_overwrite_i;

  // -----------------------------------------------------------------
  // status banks
  // -----------------------------------------------------------------
  logic [REG_W-1:0] status_one;
  logic [REG_W-1:0] status_one_next;
  logic [REG_W-1:0] status_two;
  logic [REG_W-1:0] status_two_next;

  sisl_event_bank u_bank_one (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cond_i(cond_one),
    .mask_i(mask_one_reg),
    .mode_high_i(mode_one_high_reg),
    .mode_low_i(mode_one_low_reg),
    .read_clear_i(clear_one),
    .status_o(status_one),
    .status_next_o(status_one_next)
  );

  sisl_event_bank u_bank_two (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cond_i(cond_two),
    .mask_i(mask_two_reg),
    .mode_high_i(mode_two_high_reg),
    .mode_low_i(mode_two_low_reg),
    .read_clear_i(clear_two),
    .status_o(status_two),
    .status_next_o(status_two_next)
  );

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  // unmapped offsets read zero
  wire [REG_W-1:0] read_value =
    sel_status_one ? status_one :
    sel_status_two ? (status_two & TWO_LIVE_BITS) :
    sel_mask_one ? mask_one_reg :
    sel_mode_one_high ? mode_one_high_reg :
    sel_mode_one_low ? mode_one_low_reg :
    sel_mask_two ? mask_two_reg :
    sel_mode_two_high ? mode_two_high_reg :
    sel_mode_two_low ? mode_two_low_reg : RST_RDATA;

  // -----------------------------------------------------------------
  // interrupt pin
  // -----------------------------------------------------------------
  // pin follows the state the banks are about to hold, so it lines up with status
  wire irq_next = (|status_one_next) | (|status_two_next);

  assign reg_rdata_o = rdata_reg;
  assign interrupt_o = interrupt_reg;
  assign left_sample_o = left_reg;
  assign right_sample_o = right_reg;

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mask_one_reg <= RST_MASK;
      mode_one_high_reg <= RST_MODE;
      mode_one_low_reg <= RST_MODE;
    end
    else
    begin
      if (wr_mask_one) mask_one_reg <= reg_wdata_i;
      if (wr_mode_one_high) mode_one_high_reg <= reg_wdata_i;
      if (wr_mode_one_low) mode_one_low_reg <= reg_wdata_i;
    end
  end

  // bits 7:6 of the second bank have no source, so they are never stored
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mask_two_reg <= RST_MASK;
      mode_two_high_reg <= RST_MODE;
      mode_two_low_reg <= RST_MODE;
    end
    else
    begin
      if (wr_mask_two) mask_two_reg <= reg_wdata_i & TWO_LIVE_BITS;
      if (wr_mode_two_high) mode_two_high_reg <= reg_wdata_i & TWO_LIVE_BITS;
      if (wr_mode_two_low) mode_two_low_reg <= reg_wdata_i & TWO_LIVE_BITS;
    end
  end

  // -----------------------------------------------------------------
  // output registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= RST_RDATA;
      interrupt_reg <= 1'b0;
    end
    else
    begin
      if (reg_rd_i)
        rdata_reg <= read_value;
      interrupt_reg <= irq_next;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      block_start_prev_reg <= 1'b0;
    else
      block_start_prev_reg <= transmit_block_start_i;
  end

  // samples hold between valid strobes so the output never shows a raw value
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      left_reg <= '0;
      right_reg <= '0;
    end
    else if (sample_valid_i)
    begin
      left_reg <= left_clip;
      right_reg <= right_clip;
    end
  end
endmodule

// >>> rtl/sisl_pkg.sv
// shared constants of the interrupt status, mask and trigger-mode logic
package sisl_pkg;

  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned RAW_W = 26;
  localparam int unsigned PERIOD_W = 16;
  localparam int unsigned MCLK_CNT_W = 10;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h07;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h08;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h09;
  localparam logic [7:0] ADDR_MODE_ONE_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_MODE_ONE_LOW = 8'h0B;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h0C;
  localparam logic [7:0] ADDR_MODE_TWO_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_MODE_TWO_LOW = 8'h0E;

  // ---------------------------------------------------------------
  // reset values and fixed fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] TWO_LIVE_BITS = 8'h3F;

  // bit positions, first register
  localparam int unsigned BIT_TX_SLIP = 7;
  localparam int unsigned BIT_OUT_SLIP = 6;
  localparam int unsigned BIT_RATIO = 5;
  localparam int unsigned BIT_OVR_L = 4;
  localparam int unsigned BIT_OVR_R = 3;
  localparam int unsigned BIT_CBUF_DE = 2;
  localparam int unsigned BIT_CBUF_EF = 1;
  localparam int unsigned BIT_RX_FAULT = 0;
  // bit positions, second register
  localparam int unsigned BIT_VARISPEED = 5;
  localparam int unsigned BIT_TRACKING = 4;
  localparam int unsigned BIT_UBUF_DE = 3;
  localparam int unsigned BIT_UBUF_EF = 2;
  localparam int unsigned BIT_Q_READY = 1;
  localparam int unsigned BIT_UFIFO_OVW = 0;

  // trigger mode codes, {high bit, low bit}
  localparam logic [1:0] MODE_RISE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // master clock to frame clock ratio selection
  localparam logic [1:0] CLK_SEL_256 = 2'h0;
  localparam logic [1:0] CLK_SEL_384 = 2'h1;
  localparam logic [1:0] CLK_SEL_512 = 2'h2;
  localparam logic [MCLK_CNT_W-1:0] MCLK_PER_FRAME_256 = 10'h100;
  localparam logic [MCLK_CNT_W-1:0] MCLK_PER_FRAME_384 = 10'h180;
  localparam logic [MCLK_CNT_W-1:0] MCLK_PER_FRAME_512 = 10'h200;
  localparam logic [MCLK_CNT_W-1:0] MCLK_CNT_MAX = 10'h3FF;

  localparam int unsigned RATIO_LIMIT = 3;
  localparam int unsigned Q_READ_FRAMES = 588;

  // full-scale limits of a clipped sample
  localparam logic signed [RAW_W-1:0] FULL_POS = 26'sh07FFFFF;
  localparam logic signed [RAW_W-1:0] FULL_NEG = -26'sh0800000;

  typedef enum logic [1:0] {
    SISL_CHECK_IDLE = 2'b01,
    SISL_CHECK_RUN = 2'b10
  } sisl_check_type;

endpackage

// >>> rtl/sisl_event_bank.sv
// one bank of eight sticky, maskable, mode-selected event bits
module sisl_event_bank
  import sisl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [REG_W-1:0] cond_i,
  input wire logic [REG_W-1:0] mask_i,
  input wire logic [REG_W-1:0] mode_high_i,
  input wire logic [REG_W-1:0] mode_low_i,
  input wire logic read_clear_i,
  output logic [REG_W-1:0] status_o,
  output logic [REG_W-1:0] status_next_o
);
  import sisl_pkg::*;

  logic [REG_W-1:0] cond_prev_reg;
  logic [REG_W-1:0] status_reg;
  logic [REG_W-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi = gi + 1)
    begin : g_bit
      wire [1:0] mode = {mode_high_i[gi], mode_low_i[gi]};
      wire rise = cond_i[gi] & ~cond_prev_reg[gi];
      wire fall = ~cond_i[gi] & cond_prev_reg[gi];
      // reserved code never fires
      assign hit[gi] = (mode == MODE_RISE) ? rise :
                       (mode == MODE_FALL) ? fall :
                       (mode == MODE_LEVEL) ? cond_i[gi] : 1'b0;
    end
  endgenerate

  // a fresh hit outranks the read clear; a level source still true re-sets itself
  assign status_next_o = mask_i & (hit | (status_reg & ~{REG_W{read_clear_i}}));
  assign status_o = status_reg & mask_i;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cond_prev_reg <= RST_STATUS;
      status_reg <= RST_STATUS;
    end
    else
    begin
      cond_prev_reg <= cond_i;
      status_reg <= status_next_o;
    end
  end
endmodule

// >>> rtl/sisl_ratio_check.sv
// counts master clock ticks per output frame and flags a mismatch with the selection
module sisl_ratio_check
  import sisl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic output_master_clock_i,
  input wire logic output_frame_sync_i,
  input wire logic [1:0] clk_ratio_sel_i,
  output logic mismatch_o
);
  import sisl_pkg::*;

  sisl_check_type state_reg;
  sisl_check_type state_next;
  logic [MCLK_CNT_W-1:0] count_reg;
  logic mclk_prev_reg;
  logic sync_prev_reg;
  logic mismatch_reg;
  logic [MCLK_CNT_W-1:0] expected;

  wire mclk_rise = output_master_clock_i & ~mclk_prev_reg;
  wire frame_start = output_frame_sync_i & ~sync_prev_reg;
  wire [MCLK_CNT_W-1:0] count_inc = (count_reg == MCLK_CNT_MAX) ? count_reg :
                                    count_reg + 10'h001;

  // code 11 is reserved; treat it like the default selection
  assign expected = (clk_ratio_sel_i == CLK_SEL_384) ? MCLK_PER_FRAME_384 :
                    (clk_ratio_sel_i == CLK_SEL_512) ? MCLK_PER_FRAME_512 :
                    MCLK_PER_FRAME_256;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SISL_CHECK_IDLE: if (enable_i && frame_start) state_next = SISL_CHECK_RUN;
      SISL_CHECK_RUN: if (!enable_i) state_next = SISL_CHECK_IDLE;
      default: state_next = SISL_CHECK_IDLE;
    endcase
  end

  assign mismatch_o = mismatch_reg;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SISL_CHECK_IDLE;
      count_reg <= '0;
      mclk_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      mismatch_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mclk_prev_reg <= output_master_clock_i;
      sync_prev_reg <= output_frame_sync_i;
      // a partial first frame is never judged
      mismatch_reg <= (state_reg == SISL_CHECK_RUN) && enable_i && frame_start &&
                      (count_reg != expected);
      if (frame_start)
        count_reg <= {{(MCLK_CNT_W-1){1'b0}}, mclk_rise};
      else if (mclk_rise)
        count_reg <= count_inc;
    end
  end
endmodule

// >>> sim/sisl_chk.sv
// port-level assertion checker for the interrupt status logic
module sisl_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [sisl_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [sisl_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic [sisl_pkg::REG_W-1:0] reg_rdata_o,
  input wire logic interrupt_o,
  input wire logic src_in_use_i,
  input wire logic tx_sample_slip_i,
  input wire logic receiver_fault_event_i,
  input wire logic sample_valid_i,
  input wire logic signed [sisl_pkg::RAW_W-1:0] left_raw_i,
  input wire logic signed [sisl_pkg::SAMPLE_W-1:0] left_sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sisl_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // shadow copies of both mask registers and the first bank's mode registers, updated on the same edge as the design's
  logic [7:0] m1_reg, m2_reg, hi_reg, lo_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      m1_reg <= RST_MASK;
      m2_reg <= RST_MASK;
      hi_reg <= RST_MODE;
      lo_reg <= RST_MODE;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == ADDR_MASK_ONE)
        m1_reg <= reg_wdata_i;
      if (reg_addr_i == ADDR_MASK_TWO)
        m2_reg <= reg_wdata_i & TWO_LIVE_BITS;
      if (reg_addr_i == ADDR_MODE_ONE_HIGH)
        hi_reg <= reg_wdata_i;
      if (reg_addr_i == ADDR_MODE_ONE_LOW)
        lo_reg <= reg_wdata_i;
    end
  end
  property p_reset_quiet;
    $rose(rst_n_i) |-> !interrupt_o && reg_rdata_o == RST_RDATA;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
  property p_rdata_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_two_top;
    reg_rd_i && reg_addr_i == ADDR_STATUS_TWO |=> reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_two_top: assert property (p_two_top) else $error("upper status two bits set");
  property p_mask_gate;
    reg_rd_i && reg_addr_i == ADDR_STATUS_ONE |=> (reg_rdata_o & ~$past(m1_reg)) == 8'h00;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked status bit read as one");
  property p_tx_slip;
    m1_reg[7] && {hi_reg[7], lo_reg[7]} == MODE_RISE && !src_in_use_i && $rose(tx_sample_slip_i)
      |=> interrupt_o;
  endproperty
  a_tx_slip: assert property (p_tx_slip) else $error("slip did not raise the pin");
  property p_level;
    m1_reg[0] && {hi_reg[0], lo_reg[0]} == MODE_LEVEL && receiver_fault_event_i |=> interrupt_o;
  endproperty
  a_level: assert property (p_level) else $error("level source did not hold the pin");
  property p_quiet;
    (m1_reg == 8'h00 && m2_reg == 8'h00) [*2] |=> !interrupt_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin high with all sources masked");
  property p_clip_pos;
    sample_valid_i && left_raw_i > FULL_POS |=> left_sample_o == FULL_POS[SAMPLE_W-1:0];
  endproperty
  a_clip_pos: assert property (p_clip_pos) else $error("left sample not clipped");
endmodule

bind sisl_top sisl_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .interrupt_o(interrupt_o), .src_in_use_i(src_in_use_i),
  .tx_sample_slip_i(tx_sample_slip_i), .receiver_fault_event_i(receiver_fault_event_i),
  .sample_valid_i(sample_valid_i), .left_raw_i(left_raw_i), .left_sample_o(left_sample_o));

// >>> sim/sisl_host.sv
// host controller model that owns the control port
module sisl_host (
  input wire logic clock_i,
  output logic [sisl_pkg::ADDR_W-1:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [sisl_pkg::REG_W-1:0] reg_wdata_o,
  input wire logic [sisl_pkg::REG_W-1:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock_i);
    reg_addr_o = addr;
    reg_wdata_o = data;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
  endtask
  // a read finishes two cycles after the call, far inside the subcode deadline
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock_i);
    reg_addr_o = addr;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    data = reg_rdata_i;
  endtask
endmodule

// >>> sim/sisl_top_test.sv
// self-checking bench for the interrupt status logic
module sisl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sisl_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, src1, src2, scratch;
  logic wr, rd, irq, in_use, bs_in, slave, ublock, bs, mclk, fsync;
  logic [1:0] sel;
  logic [23:0] lsamp, rsamp;
  int miscompares = 0;
  int samples_checked = 0;
  always #10 clock_i = ~clock_i;
  sisl_host host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  sisl_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .interrupt_o(irq),
    .src_in_use_i(in_use), .transmit_block_start_is_input_i(bs_in), .output_port_slave_i(slave),
    .user_block_mode_i(ublock), .clk_ratio_sel_i(sel), .tx_sample_slip_i(src1[7]),
    .transmit_block_start_i(bs), .output_port_sample_slip_i(src1[6]),
    .output_master_clock_i(mclk), .output_frame_sync_i(fsync),
    .in_frame_period_i(src1[5] ? 16'h0400 : 16'h0100), .out_frame_period_i(16'h0100),
    .sample_valid_i(src1[4] | src1[3]), .left_raw_i(src1[4] ? 26'sh0800000 : 26'sh0),
    .right_raw_i(src1[3] ? -26'sh0800001 : 26'sh0), .cbuf_d_to_e_event_i(src1[2]),
    .cbuf_e_to_f_event_i(src1[1]), .receiver_fault_event_i(src1[0]),
    .varispeed_overflow_i(src2[5]), .converter_tracking_event_i(src2[4]),
    .ubuf_d_to_e_event_i(src2[3]), .ubuf_e_to_f_event_i(src2[2]), .q_subcode_ready_i(src2[1]),
    .user_fifo_overwrite_i(src2[0]), .left_sample_o(lsamp), .right_sample_o(rsamp));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.read_reg(a, d);
    check(what, 24'(exp), 24'(d));
  endtask
  task automatic settle();
    repeat (4) @(negedge clock_i);
  endtask
  task automatic pulse(input int b, input int i);
    @(negedge clock_i);
    if (b == 0)
      src1[i] = 1'b1;
    else
      src2[i] = 1'b1;
    @(negedge clock_i);
    src1 = 8'h00;
    src2 = 8'h00;
    settle();
  endtask
  // a level source stays set across reads while true, then clears on the read after it ends
  task automatic level_run(input logic [7:0] a, input int b);
    if (b == 0)
      src1[0] = 1'b1;
    else
      src2[0] = 1'b1;
    settle();
    rchk(a, 8'h01, "level set");
    rchk(a, 8'h01, "level kept");
    src1 = 8'h00;
    src2 = 8'h00;
    settle();
    rchk(a, 8'h01, "level latched");
    rchk(a, 8'h00, "level gone");
  endtask
  // master clock ticks per frame, two bench cycles per tick
  task automatic frames(input int ticks, input int n);
    for (int f = 0; f < n * ticks; f++)
    begin
      @(negedge clock_i);
      mclk = 1'b1;
      fsync = (f % ticks) < ticks / 2;
      @(negedge clock_i);
      mclk = 1'b0;
    end
  endtask
  initial
  begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    complete_run();
  end
  initial
  begin
    {in_use, bs_in, bs, mclk, fsync, sel, src1, src2} = '0;
    slave = 1'b1;
    ublock = 1'b1;
    repeat (4) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int a = 7; a <= 14; a++)
      rchk(8'(a), 8'h00, "reset value");
    rchk(8'h20, 8'h00, "unmapped read");
    host.write_reg(ADDR_MASK_TWO, 8'hFF);
    rchk(ADDR_MASK_TWO, TWO_LIVE_BITS, "mask two");
    host.write_reg(ADDR_MASK_ONE, 8'hFF);
    rchk(ADDR_MASK_ONE, 8'hFF, "mask one");
    $display("test registers done");
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 8 - 2 * b; i++)
      begin
        pulse(b, i);
        // the right channel is rewritten by the next valid sample, so look right away
        if (b == 0 && i == 3)
          check("right clip", 24'h800000, rsamp);
        check("pin raised", 24'h1, 24'(irq));
        rchk(b ? ADDR_STATUS_TWO : ADDR_STATUS_ONE, 8'h01 << i, "status");
        rchk(b ? ADDR_STATUS_TWO : ADDR_STATUS_ONE, 8'h00, "read clears");
        check("pin released", 24'h0, 24'(irq));
      end
    check("left clip", 24'h7FFFFF, lsamp);
    $display("test sources done");
    host.write_reg(ADDR_MODE_ONE_LOW, 8'h01);
    src1[0] = 1'b1;
    settle();
    rchk(ADDR_STATUS_ONE, 8'h00, "fall on arrival");
    src1[0] = 1'b0;
    settle();
    rchk(ADDR_STATUS_ONE, 8'h01, "fall on removal");
    host.write_reg(ADDR_MODE_ONE_HIGH, 8'h01);
    host.write_reg(ADDR_MODE_ONE_LOW, 8'h00);
    level_run(ADDR_STATUS_ONE, 0);
    host.write_reg(ADDR_MODE_TWO_HIGH, 8'h01);
    level_run(ADDR_STATUS_TWO, 1);
    host.write_reg(ADDR_MODE_ONE_LOW, 8'h01);
    pulse(0, 0);
    rchk(ADDR_STATUS_ONE, 8'h00, "reserved mode");
    host.write_reg(ADDR_MODE_ONE_HIGH, 8'h00);
    host.write_reg(ADDR_MODE_ONE_LOW, 8'h00);
    host.write_reg(ADDR_MASK_ONE, 8'hFE);
    pulse(0, 0);
    check("masked pin", 24'h0, 24'(irq));
    rchk(ADDR_STATUS_ONE, 8'h00, "masked status");
    host.write_reg(ADDR_MASK_ONE, 8'hFF);
    $display("test modes done");
    in_use = 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      sel = 2'(s);
      frames(256 + 128 * s, 3);
      host.read_reg(ADDR_STATUS_ONE, scratch);
      frames(256 + 128 * s, 2);
      rchk(ADDR_STATUS_ONE, 8'h00, "ratio match");
    end
    sel = CLK_SEL_256;
    frames(384, 3);
    rchk(ADDR_STATUS_ONE, 8'h40, "ratio mismatch");
    pulse(0, 7);
    rchk(ADDR_STATUS_ONE, 8'h00, "slip with converter");
    in_use = 1'b0;
    bs_in = 1'b1;
    bs = 1'b1;
    settle();
    bs = 1'b0;
    rchk(ADDR_STATUS_ONE, 8'h80, "block start");
    ublock = 1'b0;
    pulse(1, 3);
    rchk(ADDR_STATUS_TWO, 8'h00, "user transfer off");
    $display("test configuration done");
    complete_run();
  end
endmodule
